/* File: core/pdmc_pkg.sv */
package pdmc_pkg;
   // register offsets on the plain port
   localparam logic [7:0] OFS_CTRL = 8'h82;
   localparam logic [7:0] OFS_CTRL_B = 8'h88;
   localparam logic [7:0] OFS_STATE = 8'h90;
   localparam logic [7:0] RST_CTRL = 8'h00;
   // control register fields
   localparam int BIT_STANDBY_SEL = 7;
   localparam int BIT_TIMER = 2;
   localparam int BIT_RTC = 1;
   localparam int BIT_BASIC_UART = 0;
   localparam logic [7:0] MASK_CTRL = 8'h87;
   // second control register fields
   localparam int BIT_BUS = 7;
   localparam int BIT_BREAK = 5;
   localparam int BIT_DMA = 4;
   localparam int BIT_DAC = 3;
   localparam int BIT_ADC = 2;
   localparam int BIT_UART2 = 1;
   localparam int BIT_UART1 = 0;
   localparam logic [7:0] MASK_CTRL_B = 8'hBF;
   localparam logic [7:0] WDT_ZERO = 8'h00;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [3:0] ZERO_NIB = 4'h0;
   localparam logic [1:0] ST_RESET = 2'b11;
   localparam logic [1:0] ST_SLEEP = 2'b10;
   localparam logic [1:0] ST_STANDBY = 2'b01;
   localparam logic [1:0] ST_NORMAL = 2'b00;
   typedef enum logic [2:0]
   {
      PDMC_RUN = 3'b000,
      PDMC_SLEEP = 3'b001,
      PDMC_STANDBY = 3'b010,
      PDMC_WAKE = 3'b011,
      PDMC_LOCK = 3'b100
   } pdmc_state_t;
endpackage

/* File: core/pdmc_top.sv */
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
module pdmc_top #(
   parameter int CODE_W = 12
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic manual_rst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // cpu side
   input wire logic sleep_req,
   input wire logic cpu_block_bit,
   input wire logic [3:0] irq_mask_level,
   input wire logic refresh_busy,
   // interrupt sources
   input wire logic nmi_req,
   input wire logic ext_irq_req,
   input wire logic [3:0] ext_irq_level,
   input wire logic per_irq_req,
   input wire logic [3:0] per_irq_level,
   input wire logic per_irq_rtc_clk,
   input wire logic per_irq_interval,
   input wire logic rtc_in_use,
   input wire logic [CODE_W-1:0] irq_code,
   // watchdog
   input wire logic [7:0] watchdog_count,
   input wire logic watchdog_done,
   // outputs
   output logic cpu_halt,
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic bus_clock_en,
   output logic watchdog_run,
   output logic timer_start_clr,
   output logic exc_start,
   output logic [CODE_W-1:0] event_code_reg,
   output logic [CODE_W-1:0] event_code_reg_b,
   output logic state_pin_hi,
   output logic state_pin_lo,
   output logic [10:0] module_gate,
   output logic rtc_access_ok
);
   pdmc_pkg::pdmc_state_t state_ff, nxt_state;
   logic [7:0] ctrl_ff, nxt_ctrl;
   logic [7:0] ctrl_b_ff, nxt_ctrl_b;
   logic [7:0] rdata_ff, nxt_rdata;
   logic halt_ff, nxt_halt;
   logic cclk_ff, nxt_cclk;
   logic pclk_ff, nxt_pclk;
   logic bclk_ff, nxt_bclk;
   logic wdog_ff, nxt_wdog;
   logic tclr_ff, nxt_tclr;
   logic exc_ff, nxt_exc;
   logic [CODE_W-1:0] code_ff, nxt_code;
   logic [CODE_W-1:0] code_b_ff, nxt_code_b;
   logic [1:0] pins_ff, nxt_pins;
   logic [10:0] gate_ff, nxt_gate;
   logic rtcok_ff, nxt_rtcok;
   logic any_rst;
   logic sleep_wake;
   logic standby_wake;
   logic ext_ok;
   logic per_ok;

   assign any_rst = srst | manual_rst;
   // sleep wake sources, block bit not consulted
   assign sleep_wake = nmi_req | ext_irq_req | per_irq_req;
   // standby qualification by level and clock source
   assign ext_ok = ext_irq_req & rtc_in_use & (ext_irq_level > irq_mask_level);
   assign per_ok = per_irq_req & per_irq_rtc_clk & ~per_irq_interval
      & (per_irq_level > irq_mask_level);
   assign standby_wake = nmi_req | ext_ok | per_ok;

   always_comb
   begin
      nxt_state = state_ff;
      nxt_ctrl = ctrl_ff;
      nxt_ctrl_b = ctrl_b_ff;
      nxt_rdata = pdmc_pkg::ZERO_BYTE;
      nxt_tclr = 1'b0;
      nxt_exc = 1'b0;
      nxt_code = code_ff;
      nxt_code_b = code_b_ff;
      // register writes, reserved bits forced to zero
      if (reg_wr && reg_addr == pdmc_pkg::OFS_CTRL)
      begin
         nxt_ctrl = reg_wdata & pdmc_pkg::MASK_CTRL;
      end
      if (reg_wr && reg_addr == pdmc_pkg::OFS_CTRL_B)
      begin
         nxt_ctrl_b = reg_wdata & pdmc_pkg::MASK_CTRL_B;
      end
      if (reg_rd)
      begin
         case (reg_addr)
            pdmc_pkg::OFS_CTRL: nxt_rdata = ctrl_ff;
            pdmc_pkg::OFS_CTRL_B: nxt_rdata = ctrl_b_ff;
            pdmc_pkg::OFS_STATE: nxt_rdata = {2'b00, state_ff, 1'b0, pins_ff};
            default: nxt_rdata = pdmc_pkg::ZERO_BYTE;
         endcase
      end
      // timer stop bit rising initializes timer start register
      if (nxt_ctrl[pdmc_pkg::BIT_TIMER] && !ctrl_ff[pdmc_pkg::BIT_TIMER])
      begin
         nxt_tclr = 1'b1;
      end
      case (state_ff)
         pdmc_pkg::PDMC_RUN:
         begin
            if (sleep_req)
            begin
               // standby_select sampled in the request cycle
               if (ctrl_ff[pdmc_pkg::BIT_STANDBY_SEL])
               begin
                  nxt_state = pdmc_pkg::PDMC_STANDBY;
                  nxt_tclr = 1'b1;
               end
               else
               begin
                  nxt_state = pdmc_pkg::PDMC_SLEEP;
               end
            end
         end
         pdmc_pkg::PDMC_SLEEP:
         begin
            if (sleep_wake)
            begin
               nxt_state = pdmc_pkg::PDMC_RUN;
               nxt_exc = 1'b1;
               nxt_code = irq_code;
            end
         end
         pdmc_pkg::PDMC_STANDBY:
         begin
            if (standby_wake)
            begin
               nxt_state = pdmc_pkg::PDMC_WAKE;
               nxt_code = irq_code;
               nxt_code_b = irq_code;
            end
         end
         pdmc_pkg::PDMC_WAKE:
         begin
            // settle time from watchdog
            if (watchdog_done)
            begin
               nxt_state = pdmc_pkg::PDMC_RUN;
               nxt_exc = 1'b1;
            end
         end
         pdmc_pkg::PDMC_LOCK:
         begin
            nxt_state = pdmc_pkg::PDMC_LOCK;
         end
         default:
         begin
            nxt_state = pdmc_pkg::PDMC_RUN;
         end
      endcase
      // count left running reaches zero: locked standby
      if (state_ff == pdmc_pkg::PDMC_RUN && wdog_ff && ctrl_ff[pdmc_pkg::BIT_STANDBY_SEL]
         && watchdog_count == pdmc_pkg::WDT_ZERO)
      begin
         nxt_state = pdmc_pkg::PDMC_LOCK;
         nxt_tclr = 1'b1;
      end
      if (manual_rst && state_ff != pdmc_pkg::PDMC_LOCK)
      begin
         nxt_state = pdmc_pkg::PDMC_RUN;
         nxt_ctrl = pdmc_pkg::RST_CTRL;
         nxt_ctrl_b = pdmc_pkg::RST_CTRL;
         nxt_exc = 1'b0;
      end
   end

   always_comb
   begin
      nxt_halt = 1'b1;
      nxt_cclk = 1'b0;
      nxt_pclk = 1'b0;
      nxt_bclk = 1'b0;
      nxt_wdog = 1'b0;
      nxt_pins = pdmc_pkg::ST_NORMAL;
      case (nxt_state)
         pdmc_pkg::PDMC_RUN:
         begin
            nxt_halt = 1'b0;
            nxt_cclk = 1'b1;
            nxt_pclk = 1'b1;
            nxt_bclk = 1'b1;
            // count keeps running after wake until select is cleared
            nxt_wdog = (wdog_ff | state_ff == pdmc_pkg::PDMC_WAKE)
               & nxt_ctrl[pdmc_pkg::BIT_STANDBY_SEL];
         end
         pdmc_pkg::PDMC_SLEEP:
         begin
            nxt_pclk = 1'b1;
            nxt_bclk = 1'b1;
            nxt_pins = refresh_busy ? pdmc_pkg::ST_NORMAL : pdmc_pkg::ST_SLEEP;
         end
         pdmc_pkg::PDMC_STANDBY, pdmc_pkg::PDMC_LOCK:
         begin
            nxt_pins = pdmc_pkg::ST_STANDBY;
         end
         pdmc_pkg::PDMC_WAKE:
         begin
            nxt_wdog = 1'b1;
            nxt_pins = pdmc_pkg::ST_STANDBY;
         end
         default:
         begin
            nxt_pins = pdmc_pkg::ST_NORMAL;
         end
      endcase
      if (manual_rst && state_ff != pdmc_pkg::PDMC_LOCK)
      begin
         nxt_pins = pdmc_pkg::ST_RESET;
         nxt_bclk = 1'b1;
      end
      // module gates, bits 9..4 and 2..0 forced set while peripheral clock is stopped
      nxt_gate[10] = nxt_ctrl_b[pdmc_pkg::BIT_BUS] & (nxt_state == pdmc_pkg::PDMC_SLEEP);
      nxt_gate[9] = nxt_ctrl_b[pdmc_pkg::BIT_BREAK] | ~nxt_pclk;
      nxt_gate[8] = nxt_ctrl_b[pdmc_pkg::BIT_DMA] | ~nxt_pclk;
      nxt_gate[7] = nxt_ctrl_b[pdmc_pkg::BIT_DAC] | ~nxt_pclk;
      nxt_gate[6] = nxt_ctrl_b[pdmc_pkg::BIT_ADC] | ~nxt_pclk;
      nxt_gate[5] = nxt_ctrl_b[pdmc_pkg::BIT_UART2] | ~nxt_pclk;
      nxt_gate[4] = nxt_ctrl_b[pdmc_pkg::BIT_UART1] | ~nxt_pclk;
      nxt_gate[3] = 1'b0;
      nxt_gate[2] = nxt_ctrl[pdmc_pkg::BIT_TIMER] | ~nxt_pclk;
      nxt_gate[1] = nxt_ctrl[pdmc_pkg::BIT_RTC] | ~nxt_pclk;
      nxt_gate[0] = nxt_ctrl[pdmc_pkg::BIT_BASIC_UART] | ~nxt_pclk;
      nxt_rtcok = ~nxt_ctrl[pdmc_pkg::BIT_RTC];
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         state_ff <= pdmc_pkg::PDMC_RUN;
         ctrl_ff <= pdmc_pkg::RST_CTRL;
         ctrl_b_ff <= pdmc_pkg::RST_CTRL;
         rdata_ff <= pdmc_pkg::ZERO_BYTE;
         halt_ff <= 1'b0;
         cclk_ff <= 1'b1;
         pclk_ff <= 1'b1;
         bclk_ff <= 1'b1;
         wdog_ff <= 1'b0;
         tclr_ff <= 1'b0;
         exc_ff <= 1'b0;
         code_ff <= '0;
         code_b_ff <= '0;
         pins_ff <= pdmc_pkg::ST_RESET;
         gate_ff <= '0;
         rtcok_ff <= 1'b1;
      end
      else
      begin
         state_ff <= nxt_state;
         ctrl_ff <= nxt_ctrl;
         ctrl_b_ff <= nxt_ctrl_b;
         rdata_ff <= nxt_rdata;
         halt_ff <= nxt_halt;
         cclk_ff <= nxt_cclk;
         pclk_ff <= nxt_pclk;
         bclk_ff <= nxt_bclk;
         wdog_ff <= nxt_wdog;
         tclr_ff <= nxt_tclr;
         exc_ff <= nxt_exc;
         code_ff <= nxt_code;
         code_b_ff <= nxt_code_b;
         pins_ff <= nxt_pins;
         gate_ff <= nxt_gate;
         rtcok_ff <= nxt_rtcok;
      end
   end

   assign reg_rdata = rdata_ff;
   assign cpu_halt = halt_ff;
   assign cpu_clk_en = cclk_ff;
   assign periph_clk_en = pclk_ff;
   assign bus_clock_en = bclk_ff;
   assign watchdog_run = wdog_ff;
   assign timer_start_clr = tclr_ff;
   assign exc_start = exc_ff;
   assign event_code_reg = code_ff;
   assign event_code_reg_b = code_b_ff;
   assign state_pin_hi = pins_ff[1];
   assign state_pin_lo = pins_ff[0];
   assign module_gate = gate_ff;
   assign rtc_access_ok = rtcok_ff;

   // checks
   sleep_entry_a: assert property (@(posedge sys_clk) disable iff (srst)
      state_ff == pdmc_pkg::PDMC_RUN && sleep_req && !ctrl_ff[pdmc_pkg::BIT_STANDBY_SEL]
      && !manual_rst && !(wdog_ff && ctrl_ff[pdmc_pkg::BIT_STANDBY_SEL])
      |=> cpu_halt && periph_clk_en && bus_clock_en)
      else $error("sleep entry wrong");
   sleep_pins_a: assert property (@(posedge sys_clk) disable iff (srst)
      state_ff == pdmc_pkg::PDMC_SLEEP && !manual_rst ##0 $past(refresh_busy) == 1'b0
      |-> pins_ff == pdmc_pkg::ST_SLEEP)
      else $error("sleep pins wrong");
   standby_entry_a: assert property (@(posedge sys_clk) disable iff (srst)
      state_ff == pdmc_pkg::PDMC_RUN && sleep_req && ctrl_ff[pdmc_pkg::BIT_STANDBY_SEL]
      && !manual_rst |=> !bus_clock_en && !periph_clk_en && timer_start_clr
      && pins_ff == pdmc_pkg::ST_STANDBY)
      else $error("standby entry wrong");
   sleep_wake_a: assert property (@(posedge sys_clk) disable iff (srst)
      state_ff == pdmc_pkg::PDMC_SLEEP && nmi_req && !manual_rst
      |=> exc_start && event_code_reg == $past(irq_code))
      else $error("sleep wake wrong");
   wake_wait_a: assert property (@(posedge sys_clk) disable iff (srst)
      state_ff == pdmc_pkg::PDMC_WAKE && !watchdog_done && !manual_rst
      |=> cpu_halt && !exc_start)
      else $error("woke before settle");
   mask_level_a: assert property (@(posedge sys_clk) disable iff (srst)
      state_ff == pdmc_pkg::PDMC_STANDBY && !nmi_req && !per_irq_req
      && ext_irq_level <= irq_mask_level && !manual_rst
      |=> state_ff == pdmc_pkg::PDMC_STANDBY)
      else $error("masked irq woke");
   interval_a: assert property (@(posedge sys_clk) disable iff (srst)
      state_ff == pdmc_pkg::PDMC_STANDBY && !nmi_req && !ext_irq_req && per_irq_interval
      && !manual_rst |=> state_ff == pdmc_pkg::PDMC_STANDBY)
      else $error("interval timer woke");
   lock_a: assert property (@(posedge sys_clk) disable iff (srst)
      state_ff == pdmc_pkg::PDMC_LOCK |=> state_ff == pdmc_pkg::PDMC_LOCK [*2])
      else $error("lock left");
   timer_gate_a: assert property (@(posedge sys_clk) disable iff (srst)
      reg_wr && reg_addr == pdmc_pkg::OFS_CTRL && reg_wdata[pdmc_pkg::BIT_TIMER]
      && !ctrl_ff[pdmc_pkg::BIT_TIMER] && !manual_rst
      |=> timer_start_clr && module_gate[2])
      else $error("timer gate wrong");
   mrst_a: assert property (@(posedge sys_clk) disable iff (srst)
      manual_rst && state_ff != pdmc_pkg::PDMC_LOCK
      |=> pins_ff == pdmc_pkg::ST_RESET && ctrl_ff == pdmc_pkg::RST_CTRL
      && bus_clock_en)
      else $error("manual reset wrong");
   cv_sleep: cover property (@(posedge sys_clk) state_ff == pdmc_pkg::PDMC_SLEEP
      ##1 state_ff == pdmc_pkg::PDMC_RUN);
   cv_wake: cover property (@(posedge sys_clk) state_ff == pdmc_pkg::PDMC_WAKE
      ##1 state_ff == pdmc_pkg::PDMC_RUN);
   cv_lock: cover property (@(posedge sys_clk) state_ff == pdmc_pkg::PDMC_LOCK);
endmodule

/* File: verification/pdmc_partner.sv */
`timescale 1ns/1ps
module pdmc_partner #(
   parameter logic [7:0] SETTLE = 8'h40,
   parameter logic [7:0] DONE_AT = 8'h20
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // device pins
   input wire logic watchdog_run,
   input wire logic state_pin_hi,
   input wire logic state_pin_lo,
   // watchdog side
   output logic [7:0] watchdog_count,
   output logic watchdog_done,
   // bench commands
   input wire logic pause_cmd,
   input wire logic wake_cmd,
   input wire logic pll1_stopped,
   output logic ext_irq_req,
   output logic clk_paused
);
   always_ff @(posedge sys_clk)
   begin
      // count preloaded while stopped, runs down and wraps once started
      if (srst || !watchdog_run)
         watchdog_count <= SETTLE;
      else
         watchdog_count <= watchdog_count - 8'h01;
      watchdog_done <= watchdog_run && (watchdog_count == DONE_AT);
      // clock stopped only once standby shows on the pins
      clk_paused <= pause_cmd && pll1_stopped
         && (clk_paused || {state_pin_hi, state_pin_lo} == 2'h1);
      // wake request only after the clock is back
      ext_irq_req <= !srst && wake_cmd && !clk_paused && !pause_cmd;
   end
endmodule

/* File: verification/pdmc_bench.sv */
`timescale 1ns/1ps
module pdmc_bench;
   // driven inputs
   logic sys_clk = 1'b0, srst = 1'b1, manual_rst = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
   logic reg_wr = 1'b0, reg_rd = 1'b0, sleep_req = 1'b0, cpu_block_bit = 1'b1;
   logic [3:0] irq_mask_level = 4'h0, ext_irq_level = 4'hF, per_irq_level = 4'hF;
   logic refresh_busy = 1'b0, nmi_req = 1'b0, per_irq_req = 1'b0;
   logic per_irq_rtc_clk = 1'b1, per_irq_interval = 1'b0, rtc_in_use = 1'b1;
   logic [11:0] irq_code = 12'h000;
   logic pause_cmd = 1'b0, wake_cmd = 1'b0, pll1_stopped = 1'b0;
   // observed outputs
   logic [7:0] reg_rdata, watchdog_count;
   logic ext_irq_req, watchdog_done, cpu_halt, cpu_clk_en, periph_clk_en, bus_clock_en;
   logic watchdog_run, timer_start_clr, exc_start, state_pin_hi, state_pin_lo;
   logic rtc_access_ok, clk_paused;
   logic [11:0] event_code_reg, event_code_reg_b, c;
   logic [10:0] module_gate;
   logic [1:0] pins;
   logic [3:0] clk4;
   // reference model
   logic [7:0] m_c = 8'h00, m_b = 8'h00, rnd = 8'h36;
   logic [11:0] codes[$];
   int errors = 0, compares = 0, cycles = 0, i, n;
   assign pins = {state_pin_hi, state_pin_lo};
   assign clk4 = {cpu_halt, cpu_clk_en, periph_clk_en, bus_clock_en};
   pdmc_top #(.CODE_W(12)) u_pdmc_top (.sys_clk, .srst, .manual_rst, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .sleep_req, .cpu_block_bit, .irq_mask_level,
      .refresh_busy, .nmi_req, .ext_irq_req, .ext_irq_level, .per_irq_req, .per_irq_level,
      .per_irq_rtc_clk, .per_irq_interval, .rtc_in_use, .irq_code, .watchdog_count,
      .watchdog_done, .cpu_halt, .cpu_clk_en, .periph_clk_en, .bus_clock_en, .watchdog_run,
      .timer_start_clr, .exc_start, .event_code_reg, .event_code_reg_b, .state_pin_hi,
      .state_pin_lo, .module_gate, .rtc_access_ok);
   pdmc_partner u_pdmc_partner (.sys_clk, .srst, .watchdog_run, .state_pin_hi,
      .state_pin_lo, .watchdog_count, .watchdog_done, .pause_cmd, .wake_cmd, .ext_irq_req,
      .clk_paused, .pll1_stopped);
   always #10 sys_clk = ~sys_clk;
   function automatic logic [7:0] nxt_rnd(input logic [7:0] s);
      nxt_rnd = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic [10:0] gexp(input logic sl);
      gexp = {sl & m_b[7], m_b[5:0], 1'b0, m_c[2:0]};
   endfunction
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      compares++;
      if (g !== e)
      begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask
   task automatic slp;
      @(posedge sys_clk);
      sleep_req <= 1'b1;
      @(posedge sys_clk);
      sleep_req <= 1'b0;
      #1;
   endtask
   task automatic wait_exc;
      n = 0;
      while (exc_start !== 1'b1 && n < 300)
      begin
         tick(1);
         n++;
      end
   endtask
   task automatic wrap_up;
      if (errors == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         errors++;
         wrap_up;
      end
   end
   initial
   begin
      // reset held while the clock settles
      repeat (3) @(posedge sys_clk);
      #1 chk(pins, 2'h3);
      @(posedge sys_clk);
      srst <= 1'b0;
      tick(1);
      chk(pins, 2'h0);
      rd(pdmc_pkg::OFS_CTRL, 8'h00);
      rd(pdmc_pkg::OFS_CTRL_B, 8'h00);
      for (i = 0; i < 6; i++)
      begin
         rnd = nxt_rnd(rnd);
         m_c = rnd & pdmc_pkg::MASK_CTRL;
         wr(pdmc_pkg::OFS_CTRL, rnd);
         rnd = nxt_rnd(rnd);
         m_b = rnd & pdmc_pkg::MASK_CTRL_B;
         wr(pdmc_pkg::OFS_CTRL_B, rnd);
         rd(pdmc_pkg::OFS_CTRL, m_c);
         rd(pdmc_pkg::OFS_CTRL_B, m_b);
         chk(module_gate, gexp(1'b0));
         chk(rtc_access_ok, !m_c[1]);
      end
      rd(8'h84, 8'h00);
      wr(pdmc_pkg::OFS_STATE, 8'hFF);
      rd(pdmc_pkg::OFS_STATE, 8'h00);
      wr(pdmc_pkg::OFS_CTRL, 8'h00);
      wr(pdmc_pkg::OFS_CTRL, 8'h04);
      #1 chk(timer_start_clr, 1'b1);
      wr(pdmc_pkg::OFS_CTRL, 8'h00);
      wr(pdmc_pkg::OFS_CTRL_B, 8'h80);
      m_c = 8'h00;
      m_b = 8'h80;
      // sleep, refresh, then wake by each source
      for (i = 0; i < 3; i++)
      begin
         slp;
         chk(clk4, 4'hB);
         chk(pins, 2'h2);
         chk(module_gate, gexp(1'b1));
         rd(pdmc_pkg::OFS_STATE, 8'h0A);
         @(posedge sys_clk);
         refresh_busy <= 1'b1;
         tick(1);
         chk(pins, 2'h0);
         @(posedge sys_clk);
         refresh_busy <= 1'b0;
         rnd = nxt_rnd(rnd);
         codes.push_back({4'h0, rnd});
         irq_code <= {4'h0, rnd};
         nmi_req <= (i == 0);
         wake_cmd <= (i == 1);
         per_irq_req <= (i == 2);
         wait_exc;
         chk(exc_start, 1'b1);
         chk(event_code_reg, codes.pop_front());
         chk(pins, 2'h0);
         chk(clk4, 4'h7);
         @(posedge sys_clk);
         nmi_req <= 1'b0;
         wake_cmd <= 1'b0;
         per_irq_req <= 1'b0;
         tick(2);
      end
      // standby with refused wake sources
      wr(pdmc_pkg::OFS_CTRL, 8'h80);
      @(posedge sys_clk);
      irq_mask_level <= 4'h5;
      pll1_stopped <= 1'b1;
      slp;
      chk(clk4, 4'h8);
      chk(timer_start_clr, 1'b1);
      chk(pins, 2'h1);
      rd(pdmc_pkg::OFS_STATE, 8'h11);
      for (i = 0; i < 3; i++)
      begin
         @(posedge sys_clk);
         per_irq_req <= (i == 0);
         per_irq_interval <= (i == 0);
         wake_cmd <= (i > 0);
         rtc_in_use <= (i == 2);
         ext_irq_level <= (i == 2) ? 4'h5 : 4'hF;
         tick(4);
         chk(pins, 2'h1);
      end
      @(posedge sys_clk);
      per_irq_req <= 1'b0;
      wake_cmd <= 1'b0;
      tick(3);
      chk(pins, 2'h1);
      // clock pause, then wake after the settling count
      @(posedge sys_clk);
      rtc_in_use <= 1'b1;
      ext_irq_level <= 4'h6;
      pause_cmd <= 1'b1;
      wake_cmd <= 1'b1;
      rnd = nxt_rnd(rnd);
      c = {4'h5, rnd};
      irq_code <= c;
      tick(4);
      chk(clk_paused, 1'b1);
      chk(pins, 2'h1);
      @(posedge sys_clk);
      pause_cmd <= 1'b0;
      wait_exc;
      chk(n > 31, 1'b1);
      chk(pins, 2'h0);
      chk(clk4, 4'h7);
      chk(event_code_reg, c);
      chk(event_code_reg_b, c);
      @(posedge sys_clk);
      wake_cmd <= 1'b0;
      wr(pdmc_pkg::OFS_CTRL, 8'h00);
      tick(80);
      chk(pins, 2'h0);
      chk(watchdog_run, 1'b0);
      // select left set: count expiry locks standby
      wr(pdmc_pkg::OFS_CTRL, 8'h80);
      slp;
      @(posedge sys_clk);
      nmi_req <= 1'b1;
      wait_exc;
      chk(exc_start, 1'b1);
      @(posedge sys_clk);
      nmi_req <= 1'b0;
      tick(60);
      rd(pdmc_pkg::OFS_STATE, 8'h21);
      @(posedge sys_clk);
      manual_rst <= 1'b1;
      tick(1);
      chk(pins, 2'h1);
      @(posedge sys_clk);
      manual_rst <= 1'b0;
      tick(2);
      chk(pins, 2'h1);
      @(posedge sys_clk);
      srst <= 1'b1;
      tick(1);
      chk(pins, 2'h3);
      chk(bus_clock_en, 1'b1);
      @(posedge sys_clk);
      srst <= 1'b0;
      tick(1);
      chk(pins, 2'h0);
      // manual reset out of sleep with every stop bit set
      wr(pdmc_pkg::OFS_CTRL, 8'h07);
      wr(pdmc_pkg::OFS_CTRL_B, 8'hBF);
      slp;
      @(posedge sys_clk);
      manual_rst <= 1'b1;
      tick(1);
      chk(pins, 2'h3);
      chk(bus_clock_en, 1'b1);
      @(posedge sys_clk);
      manual_rst <= 1'b0;
      tick(1);
      chk(clk4, 4'h7);
      chk(module_gate, 11'h000);
      rd(pdmc_pkg::OFS_CTRL, 8'h00);
      wrap_up;
   end
endmodule
